/* verilog/asr_pkg.sv */
/*
  asr_pkg: shared constants and types of the motion sample register bank.
  assumes: used by asr_regs and asr_regs_tb, referenced as asr_pkg::name.
*/
package asr_pkg;
  // register offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_X_HIGH = 8'h01;
  localparam logic [7:0] OFS_X_LOW  = 8'h02;
  localparam logic [7:0] OFS_Y_HIGH = 8'h03;
  localparam logic [7:0] OFS_Y_LOW  = 8'h04;
  localparam logic [7:0] OFS_Z_HIGH = 8'h05;
  localparam logic [7:0] OFS_Z_LOW  = 8'h06;
  localparam logic [7:0] OFS_IRQ    = 8'h0C;
  localparam logic [7:0] OFS_CTRL1  = 8'h2A;
  localparam logic [7:0] OFS_CTRL2  = 8'h2B;
  localparam logic [7:0] OFS_CTRL4  = 8'h2D;
  // field positions
  localparam int ACTIVE_BIT   = 0;  // control_one measuring mode
  localparam int HIGH_ONLY    = 1;  // control_one high-byte-only burst
  localparam int SOFT_RST_BIT = 6;  // control_two software reset
  localparam int DRDY_EN_BIT  = 0;  // control_four ready irq enable
  localparam int OVW_ALL_BIT  = 7;
  localparam int OVW_LSB      = 4;
  localparam int RDY_ALL_BIT  = 3;
  localparam int LOW_DATA_LSB = 6;  // low byte holds sample bits 1..0 here
  // widths
  localparam int SAMPLE_W = 10;
  localparam int AXES     = 3;
  // reset values
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] RSVD_VALUE = 8'h00;
  localparam logic [9:0] SAMPLE_RST = 10'h000;
  // default bus address of the serial slave (plain choice)
  localparam logic [6:0] DEV_ADDR = 7'h1D;
  // serial slave states, one-hot
  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_ADDR  = 8'h02,
    ST_REG   = 8'h04,
    ST_WDATA = 8'h08,
    ST_ACK   = 8'h10,
    ST_ACKH  = 8'h20,
    ST_RDATA = 8'h40,
    ST_RACK  = 8'h80
  } asr_state_t;
endpackage : asr_pkg

/* verilog/asr_line_cond.sv */
/*
  asr_line_cond: brings the serial clock and data pins into the clk domain
  and reports clock edges, start and stop conditions as one-cycle pulses.
  assumes: pins are asynchronous to clk; clk is far faster than the link.
*/
`timescale 1ns/1ps
module asr_line_cond (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start_det,
  output logic      stop_det,
  output logic      sda_s
);
  typedef struct packed {
    logic [1:0] scl_meta;  // [0] first flop, read only by [1]
    logic [1:0] sda_meta;
    logic       scl_d;     // delayed copy for edge finding
    logic       sda_d;
  } asr_lc_t;

  asr_lc_t lc_reg;
  asr_lc_t lc_next;

  // shift pins through the two-flop chains
  always_comb begin
    lc_next          = lc_reg;
    lc_next.scl_meta = {lc_reg.scl_meta[0], scl_i};
    lc_next.sda_meta = {lc_reg.sda_meta[0], sda_i};
    lc_next.scl_d    = lc_reg.scl_meta[1];
    lc_next.sda_d    = lc_reg.sda_meta[1];
  end

  // idle bus is high, so reset to high to avoid a false start
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lc_reg <= '1;
    end else begin
      lc_reg <= lc_next;
    end
  end

  // events only from the settled stage and its delayed copy
  assign sda_s     = lc_reg.sda_meta[1];
  assign scl_rise  = lc_reg.scl_meta[1] & ~lc_reg.scl_d;
  assign scl_fall  = ~lc_reg.scl_meta[1] & lc_reg.scl_d;
  assign start_det = lc_reg.scl_meta[1] & lc_reg.scl_d & lc_reg.sda_d & ~lc_reg.sda_meta[1];
  assign stop_det  = lc_reg.scl_meta[1] & lc_reg.scl_d & ~lc_reg.sda_d & lc_reg.sda_meta[1];
endmodule : asr_line_cond

/* verilog/asr_regs.sv */
/*
  asr_regs: status and sample registers of a three-axis motion sensor,
  read by the host over a two-wire serial slave on pins scl_i and sda_*.
  assumes: sample_strobe, sample_axes and sample_* come from clk-domain
  logic; the link pins are asynchronous and sampled here.
*/
`timescale 1ns/1ps
module asr_regs (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n,
  input  wire logic        sample_strobe,
  input  wire logic [2:0]  sample_axes,
  input  wire logic [9:0]  sample_x,
  input  wire logic [9:0]  sample_y,
  input  wire logic [9:0]  sample_z,
  output logic             measuring,
  output logic             sample_ready_irq_source
);
  typedef struct packed {
    asr_pkg::asr_state_t state;    // serial slave state
    asr_pkg::asr_state_t ack_to;   // where to go after an ack slot
    logic [2:0]          bitcnt;   // bit within byte
    logic [7:0]          shreg;    // shift register both ways
    logic                rw;       // 1 = host reads
    logic                ack_ok;   // host acked last read byte
    logic [7:0]          reg_addr; // current register address
    logic                oe_n;     // sda drive enable, low drives
    logic [1:0]          hi_seen;  // axis+1 whose high was just read
    logic [2:0][1:0]     hold;     // low bits captured at high read
    logic [2:0][9:0]     samp;     // current samples, x at 0
    logic [2:0]          ready;    // per-axis ready flags
    logic [2:0]          ovw;      // per-axis overwrite flags
    logic                all_rdy;
    logic                all_ovw;
    logic [7:0]          ctrl1;
    logic [7:0]          ctrl4;
    logic                irq_src;
  } asr_st_t;

  asr_st_t st_reg;
  asr_st_t st_next;

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic sda_s;

  // pin conditioning and event detection
  asr_line_cond u_line (
    .clk       (clk),
    .reset_n   (reset_n),
    .scl_i     (scl_i),
    .sda_i     (sda_i),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .start_det (start_det),
    .stop_det  (stop_det),
    .sda_s     (sda_s)
  );

  // burst order; skips low bytes in high-only mode
  function automatic logic [7:0] asr_next_addr(input logic [7:0] a, input logic fast);
    logic [7:0] n;
    n = a + 8'h01;
    case (a)
      asr_pkg::OFS_X_HIGH: n = fast ? asr_pkg::OFS_Y_HIGH : asr_pkg::OFS_X_LOW;
      asr_pkg::OFS_Y_HIGH: n = fast ? asr_pkg::OFS_Z_HIGH : asr_pkg::OFS_Y_LOW;
      asr_pkg::OFS_Z_HIGH: n = fast ? asr_pkg::OFS_STATUS : asr_pkg::OFS_Z_LOW;
      asr_pkg::OFS_Z_LOW:  n = asr_pkg::OFS_STATUS;
      default:             n = a + 8'h01;
    endcase
    return n;
  endfunction : asr_next_addr

  function automatic logic [7:0] asr_status(input asr_st_t s);
    logic [7:0] v;
    v                                      = asr_pkg::STATUS_RST;
    v[asr_pkg::OVW_ALL_BIT]                = s.all_ovw;
    v[asr_pkg::OVW_LSB +: asr_pkg::AXES]   = s.ovw;
    v[asr_pkg::RDY_ALL_BIT]                = s.all_rdy;
    v[asr_pkg::AXES-1:0]                   = s.ready;
    return v;
  endfunction : asr_status

  logic [7:0] rd_byte;   // byte served for the current address
  logic [1:0] axis_idx;  // axis of the current data address
  logic       is_high;
  logic       is_low;
  logic       do_load;   // a read byte is taken this cycle
  logic       clr_hit;   // a high read cleared flags this cycle
  logic       fast;

  // decode the current address into axis and byte kind
  always_comb begin
    axis_idx = 2'd0;
    is_high  = 1'b0;
    is_low   = 1'b0;
    if (st_reg.reg_addr >= asr_pkg::OFS_X_HIGH && st_reg.reg_addr <= asr_pkg::OFS_Z_LOW) begin
      axis_idx = 2'((st_reg.reg_addr - asr_pkg::OFS_X_HIGH) >> 1);
      is_high  = ~st_reg.reg_addr[0] ? 1'b0 : 1'b1;
      is_low   = ~is_high;
    end
  end

  // read data mux; reserved and unlisted offsets read zero
  always_comb begin
    rd_byte = asr_pkg::RSVD_VALUE;
    if (is_high) begin
      rd_byte = st_reg.samp[axis_idx][9:2];
    end else if (is_low) begin
      // low only right after its high
      if (st_reg.hi_seen == 2'(axis_idx + 2'd1)) begin
        rd_byte = {st_reg.hold[axis_idx], 6'h00};
      end
    end else begin
      case (st_reg.reg_addr)
        asr_pkg::OFS_STATUS: rd_byte = asr_status(st_reg);
        asr_pkg::OFS_IRQ:    rd_byte = {7'h00, st_reg.irq_src};
        asr_pkg::OFS_CTRL1:  rd_byte = st_reg.ctrl1;
        asr_pkg::OFS_CTRL4:  rd_byte = st_reg.ctrl4;
        default:             rd_byte = asr_pkg::RSVD_VALUE;
      endcase
    end
  end

  assign fast = st_reg.ctrl1[asr_pkg::HIGH_ONLY];
  // a byte is fetched on the falling edge that starts its first bit
  assign do_load = scl_fall &&
                   ((st_reg.state == asr_pkg::ST_ACKH && st_reg.ack_to == asr_pkg::ST_RDATA) ||
                    (st_reg.state == asr_pkg::ST_RACK && st_reg.ack_ok));

  // next state: link, register side effects, sample capture
  always_comb begin
    logic [7:0] b;
    logic       wr_go;
    logic       clr_all;
    st_next = st_reg;
    b       = {st_reg.shreg[6:0], sda_s};
    wr_go   = 1'b0;
    clr_all = 1'b0;
    clr_hit = 1'b0;

    // serial slave sequencing
    case (st_reg.state)
      asr_pkg::ST_ADDR, asr_pkg::ST_REG, asr_pkg::ST_WDATA: begin
        if (scl_rise) begin
          st_next.shreg  = b;
          st_next.bitcnt = st_reg.bitcnt + 3'd1;
          if (st_reg.bitcnt == 3'd7) begin
            st_next.state = asr_pkg::ST_ACK;
            if (st_reg.state == asr_pkg::ST_ADDR) begin
              st_next.rw     = b[0];
              st_next.ack_to = b[0] ? asr_pkg::ST_RDATA : asr_pkg::ST_REG;
              if (b[7:1] != asr_pkg::DEV_ADDR) begin
                st_next.state = asr_pkg::ST_IDLE;
              end
            end else if (st_reg.state == asr_pkg::ST_REG) begin
              st_next.reg_addr = b;
              st_next.ack_to   = asr_pkg::ST_WDATA;
            end else begin
              wr_go            = 1'b1;
              st_next.reg_addr = st_reg.reg_addr + 8'h01;
              st_next.ack_to   = asr_pkg::ST_WDATA;
            end
          end
        end
      end
      asr_pkg::ST_ACK: begin
        // pull data low through the ack clock pulse
        if (scl_fall) begin
          st_next.oe_n  = 1'b0;
          st_next.state = asr_pkg::ST_ACKH;
        end
      end
      asr_pkg::ST_ACKH: begin
        if (scl_fall) begin
          st_next.oe_n   = 1'b1;
          st_next.bitcnt = 3'd0;
          st_next.state  = st_reg.ack_to;
        end
      end
      asr_pkg::ST_RDATA: begin
        if (scl_fall) begin
          st_next.bitcnt = st_reg.bitcnt + 3'd1;
          st_next.shreg  = {st_reg.shreg[6:0], 1'b0};
          st_next.oe_n   = st_reg.shreg[6];
          if (st_reg.bitcnt == 3'd7) begin
            // release for the host's ack bit
            st_next.oe_n  = 1'b1;
            st_next.state = asr_pkg::ST_RACK;
          end
        end
      end
      asr_pkg::ST_RACK: begin
        if (scl_rise) begin
          st_next.ack_ok = ~sda_s;
        end
        if (scl_fall) begin
          st_next.bitcnt = 3'd0;
          // a not-ack ends the burst, wait for stop
          st_next.state  = st_reg.ack_ok ? asr_pkg::ST_RDATA : asr_pkg::ST_IDLE;
        end
      end
      asr_pkg::ST_IDLE: begin
        st_next.oe_n = 1'b1;
      end
      default: begin
        st_next.state = asr_pkg::ST_IDLE;
      end
    endcase

    // fetch one read byte and apply its read side effects
    if (do_load) begin
      st_next.shreg    = rd_byte;
      st_next.oe_n     = rd_byte[7];
      st_next.reg_addr = asr_next_addr(st_reg.reg_addr, fast);
      st_next.hi_seen  = 2'd0;
      if (is_high) begin
        // capture low bits at high read
        st_next.hold[axis_idx]  = st_reg.samp[axis_idx][1:0];
        st_next.hi_seen         = 2'(axis_idx + 2'd1);
        st_next.ovw[axis_idx]   = 1'b0;
        st_next.ready[axis_idx] = 1'b0;
        clr_hit                 = 1'b1;
      end
    end

    // combined flags drop once a high read leaves no ready flag set
    if (clr_hit && st_next.ready == 3'b000) begin
      st_next.all_rdy = 1'b0;
      st_next.all_ovw = 1'b0;
    end

    // new samples land after the read clears so a set wins over a high read
    if (sample_strobe && st_reg.ctrl1[asr_pkg::ACTIVE_BIT]) begin
      for (int a = 0; a < asr_pkg::AXES; a++) begin
        if (sample_axes[a]) begin
          if (st_next.ready[a]) begin
            st_next.ovw[a] = 1'b1;
            st_next.all_ovw = 1'b1;
          end
          st_next.samp[a]  = sample_axes[a] ? (a == 0 ? sample_x : (a == 1 ? sample_y : sample_z))
                                            : st_reg.samp[a];
          st_next.ready[a] = 1'b1;
          st_next.all_rdy  = 1'b1;
        end
      end
    end

    // register writes
    if (wr_go) begin
      case (st_reg.reg_addr)
        asr_pkg::OFS_CTRL1: begin
          // only the mode bit moves while measuring
          if (!st_reg.ctrl1[asr_pkg::ACTIVE_BIT]) begin
            st_next.ctrl1 = b;
          end else begin
            st_next.ctrl1[asr_pkg::ACTIVE_BIT] = b[asr_pkg::ACTIVE_BIT];
          end
          if (!st_reg.ctrl1[asr_pkg::ACTIVE_BIT] && b[asr_pkg::ACTIVE_BIT]) begin
            clr_all = 1'b1;
          end
        end
        asr_pkg::OFS_CTRL2: begin
          // reset bit honoured in either mode; self-clearing
          if (b[asr_pkg::SOFT_RST_BIT]) begin
            clr_all       = 1'b1;
            st_next.ctrl1 = asr_pkg::CTRL_RST;
            st_next.ctrl4 = asr_pkg::CTRL_RST;
          end
        end
        asr_pkg::OFS_CTRL4: begin
          if (!st_reg.ctrl1[asr_pkg::ACTIVE_BIT]) begin
            st_next.ctrl4 = b;
          end
        end
        default: begin
          st_next.ctrl4 = st_next.ctrl4;
        end
      endcase
    end

    // status and samples back to defaults
    if (clr_all) begin
      st_next.ready   = 3'b000;
      st_next.ovw     = 3'b000;
      st_next.all_rdy = 1'b0;
      st_next.all_ovw = 1'b0;
      st_next.hi_seen = 2'd0;
      st_next.hold    = '0;
      for (int a = 0; a < asr_pkg::AXES; a++) begin
        st_next.samp[a] = asr_pkg::SAMPLE_RST;
      end
    end

    // irq source tracks combined flags when enabled
    st_next.irq_src = st_next.ctrl4[asr_pkg::DRDY_EN_BIT] &
                      (st_next.all_rdy | st_next.all_ovw);

    // start and stop override the link sequencing
    if (start_det) begin
      st_next.state  = asr_pkg::ST_ADDR;
      st_next.bitcnt = 3'd0;
      st_next.oe_n   = 1'b1;
    end
    if (stop_det) begin
      st_next.state    = asr_pkg::ST_IDLE;
      st_next.oe_n     = 1'b1;
      st_next.hi_seen  = 2'd0;
      st_next.reg_addr = asr_pkg::OFS_STATUS;
    end
  end

  // single state register, reset to idle defaults
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg          <= '0;
      st_reg.state    <= asr_pkg::ST_IDLE;
      st_reg.ack_to   <= asr_pkg::ST_IDLE;
      st_reg.oe_n     <= 1'b1;
      st_reg.ctrl1    <= asr_pkg::CTRL_RST;
      st_reg.ctrl4    <= asr_pkg::CTRL_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // open-drain data pin only ever pulls low
  assign sda_o                   = 1'b0;
  assign sda_oe_n                = st_reg.oe_n;
  assign measuring               = st_reg.ctrl1[asr_pkg::ACTIVE_BIT];
  assign sample_ready_irq_source = st_reg.irq_src;
endmodule : asr_regs

/* dv/asr_regs_sva.sv */
/*
  asr_regs_sva: port-level assertions on the motion sample register bank.
  assumes: bound to asr_regs; the host keeps scl toggling inside frames.
*/
`timescale 1ns/1ps
module asr_regs_chk (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_n,
  input wire logic       sample_strobe,
  input wire logic [2:0] sample_axes,
  input wire logic [9:0] sample_x,
  input wire logic [9:0] sample_y,
  input wire logic [9:0] sample_z,
  input wire logic       measuring,
  input wire logic       sample_ready_irq_source
);
  logic       scl_d_reg;     // scl one cycle ago
  logic [7:0] fall_cnt_reg;  // cycles since scl fell
  logic [7:0] edge_cnt_reg;  // cycles since any scl edge
  logic [7:0] high_cnt_reg;  // cycles scl has stayed high
  // saturating, so a long idle bus never wraps back to small counts
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_d_reg    <= 1'b1;
      fall_cnt_reg <= 8'hFF;
      edge_cnt_reg <= 8'hFF;
      high_cnt_reg <= 8'h00;
    end else begin
      scl_d_reg    <= scl_i;
      fall_cnt_reg <= (scl_d_reg && !scl_i) ? 8'h00 : fall_cnt_reg + {7'h00, fall_cnt_reg != 8'hFF};
      edge_cnt_reg <= (scl_d_reg != scl_i) ? 8'h00 : edge_cnt_reg + {7'h00, edge_cnt_reg != 8'hFF};
      high_cnt_reg <= !scl_i ? 8'h00 : high_cnt_reg + {7'h00, high_cnt_reg != 8'hFF};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sda_low_only_a: assert property (sda_o == 1'b0)
    else $error("sda data output not low");
  drive_after_fall_a: assert property ($changed(sda_oe_n) |-> fall_cnt_reg <= 8'd6)
    else $error("sda drive changed away from scl fall");
  idle_release_a: assert property (high_cnt_reg > 8'd6 |-> sda_oe_n)
    else $error("sda held while bus idle");
  clear_on_start_a: assert property ($rose(measuring) ##1 (!sample_strobe)[*3] |-> !sample_ready_irq_source)
    else $error("ready source survived measuring start");
  irq_fall_link_a: assert property ($fell(sample_ready_irq_source) |-> edge_cnt_reg <= 8'd8)
    else $error("ready source fell without a read");
  irq_rise_cause_a: assert property ($rose(sample_ready_irq_source) |->
    $past(sample_strobe) || edge_cnt_reg <= 8'd8)
    else $error("ready source rose without a sample");
  idle_ignore_a: assert property (sample_strobe && !measuring && edge_cnt_reg > 8'd8
    |=> $stable(sample_ready_irq_source)[*2])
    else $error("sample taken while idle");
  mode_link_a: assert property ($changed(measuring) |-> edge_cnt_reg <= 8'd8)
    else $error("mode changed without a write");
  cover property ($rose(sample_ready_irq_source));
  cover property ($rose(measuring));
  cover property ($fell(sda_oe_n));
endmodule : asr_regs_chk
bind asr_regs asr_regs_chk u_chk (.clk(clk), .reset_n(reset_n), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_n(sda_oe_n), .sample_strobe(sample_strobe),
  .sample_axes(sample_axes), .sample_x(sample_x), .sample_y(sample_y), .sample_z(sample_z),
  .measuring(measuring), .sample_ready_irq_source(sample_ready_irq_source));

/* dv/asr_host_model.sv */
/*
  asr_host_model: two-wire host that frames bytes on scl and the sda wire.
  assumes: clk at 20 ns; sda_w is the resolved wire with a pull-up.
*/
`timescale 1ns/1ps
module asr_host_model (
  input  wire logic clk,
  input  wire logic sda_w,
  output logic      scl,
  output logic      sda_low
);
  logic [8:0] res;    // last transfer: ack bit and byte seen on the wire
  int         n_res;  // transfers finished
  // scl idles high, so the link clock stands still between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    n_res = 0;
  end
  // low 5 clocks, high 3: 160 ns bit; data moves well inside the low phase
  task automatic bit_io(input logic b, output logic r);
    repeat (4) @(posedge clk);
    sda_low <= !b;
    @(posedge clk);
    scl <= 1'b1;
    repeat (2) @(posedge clk);
    r = sda_w;
    @(posedge clk);
    scl <= 1'b0;
  endtask : bit_io
  // start or repeated start: sda falls while scl high
  task automatic start();
    sda_low <= 1'b0;
    repeat (5) @(posedge clk);
    scl <= 1'b1;
    repeat (2) @(posedge clk);
    sda_low <= 1'b1;
    repeat (3) @(posedge clk);
    scl <= 1'b0;
  endtask : start
  task automatic stop();
    sda_low <= 1'b1;
    repeat (5) @(posedge clk);
    scl <= 1'b1;
    repeat (3) @(posedge clk);
    sda_low <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : stop
  // eight bits msb first, then the ack slot
  task automatic xfer(input logic [7:0] d, input logic a);
    logic [8:0] r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(a, r[8]);
    res = r;
    n_res++;
  endtask : xfer
endmodule : asr_host_model

/* dv/asr_regs_tb.sv */
/*
  asr_regs_tb: drives samples and host reads, compares each byte seen.
  assumes: asr_pkg compiled first; checker bound by its own file.
*/
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module asr_regs_tb;
  localparam logic [7:0] WR = {asr_pkg::DEV_ADDR, 1'b0};  // write header
  localparam logic [7:0] RD = {asr_pkg::DEV_ADDR, 1'b1};  // read header
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       sample_strobe = 1'b0;
  logic [2:0] sample_axes = 3'h0;
  logic [9:0] sample_x = 10'h000;
  logic [9:0] sample_y = 10'h000;
  logic [9:0] sample_z = 10'h000;
  logic       scl, sda_low, sda_w, sda_o, sda_oe_n, measuring, irq;
  logic [9:0] smp [3];   // sample each axis should hold
  logic [8:0] exq [$];   // expected ack and byte per transfer
  int         errors = 0;
  int         tests_run = 0;
  int         seed = 32'hE11AEE7F;
  always #10 clk = ~clk;
  // open drain wire: low if anyone pulls, else pulled up
  assign sda_w = !(sda_low || !sda_oe_n);
  asr_regs dut (.clk(clk), .reset_n(reset_n), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .sample_strobe(sample_strobe), .sample_axes(sample_axes),
    .sample_x(sample_x), .sample_y(sample_y), .sample_z(sample_z), .measuring(measuring),
    .sample_ready_irq_source(irq));
  asr_host_model host (.clk(clk), .sda_w(sda_w), .scl(scl), .sda_low(sda_low));
  // oldest note against every finished transfer
  always @(host.n_res) begin : compare
    logic [8:0] e;
    e = exq.pop_front();
    `CHK(host.res, e) // wire byte
  end
  function automatic logic [7:0] hi(input int a);
    return smp[a][9:2];
  endfunction : hi
  function automatic logic [7:0] lo(input int a);
    return {smp[a][1:0], 6'h00};
  endfunction : lo
  task automatic x(input logic [7:0] d, input logic a, input logic [8:0] e);
    exq.push_back(e);
    host.xfer(d, a);
  endtask : x
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.start();
    x(WR, 1'b1, {1'b0, WR});
    x(a, 1'b1, {1'b0, a});
    x(d, 1'b1, {1'b0, d});
    host.stop();
  endtask : wr
  // burst read; last byte refused by the host
  task automatic rd(input logic [7:0] a, input logic [7:0] e []);
    host.start();
    x(WR, 1'b1, {1'b0, WR});
    x(a, 1'b1, {1'b0, a});
    host.start();
    x(RD, 1'b1, {1'b0, RD});
    foreach (e[i]) x(8'hFF, 1'(i == e.size() - 1), {1'(i == e.size() - 1), e[i]});
    host.stop();
  endtask : rd
  // random values on every axis; only flagged axes should land
  task automatic strobe(input logic [2:0] ax);
    logic [9:0] v [3];
    foreach (v[i]) v[i] = 10'($random(seed));
    foreach (v[i]) if (ax[i] && measuring) smp[i] = v[i];
    sample_axes <= ax;
    sample_x <= v[0];
    sample_y <= v[1];
    sample_z <= v[2];
    sample_strobe <= 1'b1;
    @(posedge clk);
    sample_strobe <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : strobe
  task automatic conclude();
    $display("comparisons %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude
  initial begin : watchdog
    repeat (40000) @(posedge clk);
    errors++;
    conclude();
  end
  initial begin : main
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    repeat (5) @(posedge clk);
    foreach (smp[i]) smp[i] = asr_pkg::SAMPLE_RST;
    rd(8'h00, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}); // defaults
    wr(asr_pkg::OFS_CTRL4, 8'h01); // enable while idle
    wr(asr_pkg::OFS_CTRL1, 8'h01); // start measuring
    `CHK(measuring, 1'b1) // mode bit
    strobe(3'h7);
    `CHK(irq, 1'b1) // ready source
    strobe(3'h7);
    rd(8'h00, '{8'hFF, hi(0), lo(0), hi(1), lo(1), hi(2), lo(2), 8'h00});
    `CHK(irq, 1'b0) // cleared by data
    strobe(3'h3);
    strobe(3'h3);
    rd(8'h01, '{hi(0)}); // x high only
    rd(8'h00, '{8'hAA}); // partial clear
    `CHK(irq, 1'b1) // not cleared by status
    fork
      rd(8'h03, '{hi(1), lo(1), hi(2)}); // same sample pair
      begin
        repeat (260) @(posedge clk);
        strobe(3'h2);
      end
    join
    rd(8'h04, '{8'h00}); // direct low read
    rd(8'h01, '{hi(0), lo(0), hi(1), lo(1), hi(2), lo(2)});
    rd(8'h00, '{8'h00}); // all highs read
    wr(asr_pkg::OFS_CTRL1, 8'h00); // idle before config
    strobe(3'h7);
    rd(8'h00, '{8'h00}); // idle ignores samples
    wr(asr_pkg::OFS_CTRL1, 8'h02);
    wr(asr_pkg::OFS_CTRL1, 8'h03); // start again
    rd(8'h00, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00}); // cleared, skip lows
    strobe(3'h7);
    rd(8'h00, '{8'h0F, hi(0), hi(1), hi(2), 8'h00}); // high only burst
    wr(asr_pkg::OFS_CTRL1, 8'h01); // ignored while measuring
    wr(asr_pkg::OFS_CTRL4, 8'h00); // ignored while measuring
    strobe(3'h7);
    `CHK(irq, 1'b1) // enable kept
    rd(asr_pkg::OFS_IRQ, '{8'h01}); // source readable
    rd(asr_pkg::OFS_CTRL1, '{8'h03}); // high-only bit kept
    rd(8'h00, '{8'h0F, hi(0), hi(1), hi(2), 8'h00}); // still skipping
    host.start();
    x(RD, 1'b1, {1'b0, RD});
    x(8'hFF, 1'b1, {1'b1, 8'h00}); // address back to status
    host.stop();
    host.start();
    x({~asr_pkg::DEV_ADDR, 1'b0}, 1'b1, {1'b1, ~asr_pkg::DEV_ADDR, 1'b0}); // foreign header
    host.stop();
    // software reset while measuring clears flags, samples and control
    strobe(3'h7);
    wr(asr_pkg::OFS_CTRL2, 8'h40); // reset honoured while measuring
    `CHK(measuring, 1'b0) // mode back to idle
    `CHK(irq, 1'b0) // flags and enable cleared
    rd(8'h00, '{8'h00, 8'h00, 8'h00}); // status and samples cleared
    conclude();
  end
endmodule : asr_regs_tb
